// *** rtl/ocb_break_ctrl.sv ***
`timescale 1ns/1ps
`include "ocb_map.svh"
module ocb_break_ctrl #(
    parameter int RESTORE_CYC = `OCB_RESTORE_CYC,
    parameter bit POST_ONLY = 1'b0,
    parameter bit HAS_OPEN_OPT = 1'b1,
    parameter bit HAS_SERIAL_FRZ = 1'b1
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic pin_reset_in,
    input wire logic force_halt_in,
    input wire logic resume_in,
    input wire ocb_pkg::ocb_slot_mode_t slot_mode_in [`OCB_NSLOT],
    input wire logic [`OCB_AW-1:0] slot_addr_in [`OCB_NSLOT],
    input wire logic [1:0] slot_acc_in [`OCB_NSLOT],
    input wire logic timer_frz_en_in,
    input wire logic serial_frz_en_in,
    input wire logic open_brk_en_in,
    input wire logic restore_en_in,
    input wire logic fetch_valid_in,
    input wire logic [`OCB_AW-1:0] fetch_addr_in,
    input wire logic [15:0] fetch_opcode_in,
    input wire logic retire_in,
    input wire logic [`OCB_AW-1:0] next_pc_in,
    input wire logic standby_in,
    input wire logic data_valid_in,
    input wire logic data_we_in,
    input wire logic [`OCB_AW-1:0] data_addr_in,
    input wire logic obrk_pin_in,
    output logic cpu_stall_out,
    output logic wake_out,
    output logic halted_out,
    output logic [2:0] cause_out,
    output logic [`OCB_AW-1:0] halt_pc_out,
    output logic timer_frz_out,
    output logic serial_frz_out,
    output logic obrk_pin_out,
    output logic obrk_pin_oe_out,
    output logic restore_busy_out
);
    import ocb_pkg::*;
    typedef struct packed {
        ocb_state_t st;
        logic [2:0] cause;
        logic [`OCB_AW-1:0] pc;
        logic [15:0] cnt;
        logic frc_s1;
        logic frc_s2;
        logic rst_s1;
        logic rst_s2;
        logic rst_d;
        logic [2:0] post_cause;
    } ocb_regs_t;
    ocb_regs_t r, nxt;
    logic [`OCB_NSLOT-1:0] pre_hit, post_hit, acc_hit;
    logic pin_rst_rise;
    logic swbrk;
    logic obrk_float;

    for (genvar i = 0; i < `OCB_NSLOT; i++) begin : g_slot
        ocb_slot_match u_match (
            .mode_in(slot_mode_in[i]),
            .addr_in(slot_addr_in[i]),
            .acc_type_in(slot_acc_in[i]),
            .fetch_valid_in(fetch_valid_in),
            .fetch_addr_in(fetch_addr_in),
            .data_valid_in(data_valid_in),
            .data_we_in(data_we_in),
            .data_addr_in(data_addr_in),
            .pre_hit_out(pre_hit[i]),
            .post_hit_out(post_hit[i]),
            .acc_hit_out(acc_hit[i])
        );
    end

    assign pin_rst_rise = r.rst_s2 && !r.rst_d;
    assign swbrk = fetch_valid_in && (fetch_opcode_in == `OCB_BRK_OPCODE);

    always_comb begin
        nxt = r;
        nxt.frc_s1 = force_halt_in;
        nxt.frc_s2 = r.frc_s1;
        nxt.rst_s1 = pin_reset_in;
        nxt.rst_s2 = r.rst_s1;
        nxt.rst_d = r.rst_s2;
        case (r.st)
            OCB_RUN: begin
                // Sources are prioritised so one cause is reported per halt.
                if (r.frc_s2) begin
                    nxt.st = OCB_HALTED;
                    nxt.cause = `OCB_CAUSE_FORCED;
                    // Standby has already retired, so next_pc is the follower.
                    nxt.pc = next_pc_in;
                end else if (swbrk) begin
                    nxt.st = OCB_HALTED;
                    nxt.cause = `OCB_CAUSE_SWBRK;
                    nxt.pc = fetch_addr_in;
                end else if (!POST_ONLY && (|pre_hit)) begin
                    nxt.st = OCB_HALTED;
                    nxt.cause = `OCB_CAUSE_EXEC_PRE;
                    nxt.pc = fetch_addr_in;
                end else if (|acc_hit) begin
                    nxt.st = OCB_HALTED;
                    nxt.cause = `OCB_CAUSE_ACCESS;
                    nxt.pc = next_pc_in;
                end else if ((|post_hit) || (POST_ONLY && (|pre_hit))) begin
                    nxt.st = OCB_POST_WAIT;
                    nxt.post_cause = `OCB_CAUSE_EXEC_POST;
                end
            end
            OCB_POST_WAIT: begin
                if (retire_in) begin
                    nxt.st = OCB_HALTED;
                    nxt.cause = r.post_cause;
                    nxt.pc = next_pc_in;
                end
            end
            OCB_HALTED: begin
                if (resume_in) begin
                    nxt.st = OCB_RUN;
                end
            end
            OCB_RESTORE: begin
                if (r.cnt == 16'h0001) begin
                    nxt.st = OCB_RUN;
                end
                nxt.cnt = r.cnt - 16'h0001;
            end
            default: nxt.st = OCB_RUN;
        endcase
        // A pin reset overrides everything; restore holds the CPU briefly.
        if (pin_rst_rise) begin
            nxt.cause = `OCB_CAUSE_NONE;
            if (restore_en_in) begin
                nxt.st = OCB_RESTORE;
                nxt.cnt = 16'(RESTORE_CYC);
            end else begin
                nxt.st = OCB_RUN;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign halted_out = (r.st == OCB_HALTED);
    assign cpu_stall_out = (r.st == OCB_HALTED) || (r.st == OCB_RESTORE);
    assign wake_out = r.frc_s2 && standby_in;
    assign cause_out = r.cause;
    assign halt_pc_out = r.pc;
    assign restore_busy_out = (r.st == OCB_RESTORE);
    assign timer_frz_out = halted_out && timer_frz_en_in;
    assign serial_frz_out = halted_out && HAS_SERIAL_FRZ
                            && serial_frz_en_in;
    assign obrk_float = halted_out && (HAS_OPEN_OPT ? open_brk_en_in
                                                    : timer_frz_en_in);
    assign obrk_pin_out = obrk_pin_in;
    assign obrk_pin_oe_out = !obrk_float;

    AST_HALT_STICKY: assert property (@(posedge mclk_in) disable iff (srst_in)
        halted_out && !resume_in && !$rose(r.rst_s2) |=> halted_out)
        else $error("Halted status dropped without resume.");
    AST_FORCE_HALTS: assert property (@(posedge mclk_in) disable iff (srst_in)
        r.st == OCB_RUN && r.frc_s2 && !pin_rst_rise
        |=> halted_out && cause_out == `OCB_CAUSE_FORCED)
        else $error("Forced request did not halt.");
    AST_PRE_HALT: assert property (@(posedge mclk_in) disable iff (srst_in)
        r.st == OCB_RUN && !r.frc_s2 && !swbrk && !POST_ONLY && |pre_hit
        && !pin_rst_rise |=> halted_out && halt_pc_out == $past(fetch_addr_in))
        else $error("Pre-execution match did not halt at its address.");
    AST_POST_WAIT: assert property (@(posedge mclk_in) disable iff (srst_in)
        r.st == OCB_POST_WAIT && !retire_in && !pin_rst_rise
        |=> !halted_out)
        else $error("Post-execution halted before completion.");
    AST_SWBRK: assert property (@(posedge mclk_in) disable iff (srst_in)
        r.st == OCB_RUN && !r.frc_s2 && swbrk && !pin_rst_rise
        |=> cause_out == `OCB_CAUSE_SWBRK)
        else $error("Break opcode did not halt.");
    AST_WAKE: assert property (@(posedge mclk_in) disable iff (srst_in)
        r.frc_s2 && standby_in |-> wake_out)
        else $error("Forced halt did not wake standby.");
    AST_TIMER_FRZ: assert property (@(posedge mclk_in) disable iff (srst_in)
        timer_frz_out == (halted_out && timer_frz_en_in))
        else $error("Timer freeze mismatch.");
    AST_OBRK: assert property (@(posedge mclk_in) disable iff (srst_in)
        !halted_out |-> obrk_pin_oe_out)
        else $error("Open-break pin floated while running.");
    AST_RESTORE: assert property (@(posedge mclk_in) disable iff (srst_in)
        pin_rst_rise && restore_en_in |=> restore_busy_out [*2])
        else $error("Restore hold too short.");
endmodule

// *** rtl/ocb_map.svh ***
`ifndef OCB_MAP_SVH
`define OCB_MAP_SVH
`define OCB_NSLOT 4
`define OCB_AW 20
`define OCB_BRK_OPCODE 16'hff61
`define OCB_CAUSE_NONE 3'h0
`define OCB_CAUSE_FORCED 3'h1
`define OCB_CAUSE_EXEC_PRE 3'h2
`define OCB_CAUSE_EXEC_POST 3'h3
`define OCB_CAUSE_ACCESS 3'h4
`define OCB_CAUSE_SWBRK 3'h5
`define OCB_CAUSE_RESTORE 3'h6
`define OCB_ACC_READ 0
`define OCB_ACC_WRITE 1
`define OCB_RESTORE_NS 2000
`define OCB_CLK_NS 25
`define OCB_RESTORE_CYC ((`OCB_RESTORE_NS + `OCB_CLK_NS - 1) / `OCB_CLK_NS)
`endif

// *** rtl/ocb_pkg.sv ***
package ocb_pkg;
    typedef enum logic [1:0] {
        OCB_SLOT_OFF,
        OCB_SLOT_EXEC_PRE,
        OCB_SLOT_EXEC_POST,
        OCB_SLOT_ACCESS
    } ocb_slot_mode_t;
    typedef enum logic [1:0] {
        OCB_RUN,
        OCB_POST_WAIT,
        OCB_HALTED,
        OCB_RESTORE
    } ocb_state_t;
endpackage

// *** rtl/ocb_slot_match.sv ***
`timescale 1ns/1ps
`include "ocb_map.svh"
module ocb_slot_match (
    input wire ocb_pkg::ocb_slot_mode_t mode_in,
    input wire logic [`OCB_AW-1:0] addr_in,
    input wire logic [1:0] acc_type_in,
    input wire logic fetch_valid_in,
    input wire logic [`OCB_AW-1:0] fetch_addr_in,
    input wire logic data_valid_in,
    input wire logic data_we_in,
    input wire logic [`OCB_AW-1:0] data_addr_in,
    output logic pre_hit_out,
    output logic post_hit_out,
    output logic acc_hit_out
);
    import ocb_pkg::*;
    logic fetch_eq;
    logic type_ok;
    assign fetch_eq = fetch_valid_in && (fetch_addr_in == addr_in);
    assign pre_hit_out = fetch_eq && (mode_in == OCB_SLOT_EXEC_PRE);
    assign post_hit_out = fetch_eq && (mode_in == OCB_SLOT_EXEC_POST);
    assign type_ok = data_we_in ? acc_type_in[`OCB_ACC_WRITE]
                                : acc_type_in[`OCB_ACC_READ];
    assign acc_hit_out = data_valid_in && (mode_in == OCB_SLOT_ACCESS)
                         && (data_addr_in == addr_in) && type_ok;
endmodule

// *** bench/ocb_probe_model.sv ***
`timescale 1ns/1ps
`include "ocb_map.svh"
// Probe side: plants the break opcode and resumes after a set delay.
module ocb_probe_model (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic halted_in,
    input wire logic [7:0] delay_in,
    input wire logic [`OCB_AW-1:0] fetch_addr_in,
    input wire logic [`OCB_AW-1:0] sw_addr_in,
    input wire logic sw_en_in,
    output logic resume_out,
    output logic [15:0] opcode_out
);
    logic [7:0] cnt_r;
    // A slow probe is modelled by a long delay, so stickiness is visible.
    always_ff @(posedge mclk_in) begin
        if (srst_in || !halted_in || resume_out) begin
            cnt_r <= 8'h00;
            resume_out <= 1'b0;
        end else if (cnt_r == delay_in) begin
            resume_out <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    assign opcode_out = (sw_en_in && fetch_addr_in == sw_addr_in) ?
        `OCB_BRK_OPCODE : 16'h0000;
endmodule

// *** bench/test_ocb_break_ctrl.sv ***
`timescale 1ns/1ps
`include "ocb_map.svh"
module test_ocb_break_ctrl;
    import ocb_pkg::*;
    localparam int RC = 4;
    logic clk, rst, prst, frc, res, tfe, sfe, obe, rse, swe;
    ocb_slot_mode_t smode [`OCB_NSLOT];
    logic [`OCB_AW-1:0] saddr [`OCB_NSLOT];
    logic [1:0] sacc [`OCB_NSLOT];
    logic fv, ret, sby, dv, dwe, opin;
    logic [`OCB_AW-1:0] fa, npc, da, swa, hpc;
    logic [15:0] op;
    logic stall, wake, hlt, tfo, sfo, obo, oeo, rbusy;
    logic [2:0] cause;
    logic [7:0] dly;
    int fail_count, n_checks, k;
    ocb_break_ctrl #(.RESTORE_CYC(RC)) uut (.mclk_in(clk), .srst_in(rst),
        .pin_reset_in(prst), .force_halt_in(frc), .resume_in(res),
        .slot_mode_in(smode), .slot_addr_in(saddr), .slot_acc_in(sacc),
        .timer_frz_en_in(tfe), .serial_frz_en_in(sfe),
        .open_brk_en_in(obe), .restore_en_in(rse), .fetch_valid_in(fv),
        .fetch_addr_in(fa), .fetch_opcode_in(op), .retire_in(ret),
        .next_pc_in(npc), .standby_in(sby), .data_valid_in(dv),
        .data_we_in(dwe), .data_addr_in(da), .obrk_pin_in(opin),
        .cpu_stall_out(stall), .wake_out(wake), .halted_out(hlt),
        .cause_out(cause), .halt_pc_out(hpc), .timer_frz_out(tfo),
        .serial_frz_out(sfo), .obrk_pin_out(obo), .obrk_pin_oe_out(oeo),
        .restore_busy_out(rbusy));
    ocb_probe_model probe (.mclk_in(clk), .srst_in(rst), .halted_in(hlt),
        .delay_in(dly), .fetch_addr_in(fa), .sw_addr_in(swa),
        .sw_en_in(swe), .resume_out(res), .opcode_out(op));
    task automatic chk(input logic [19:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_lvl(input logic v, input int lim);
        k = 0;
        while (hlt !== v && k < lim) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    task automatic fetch(input logic [19:0] a);
        @(posedge clk);
        fv <= 1'b1;
        fa <= a;
        @(posedge clk);
        fv <= 1'b0;
    endtask
    task automatic dacc(input logic [19:0] a, input logic w);
        @(posedge clk);
        dv <= 1'b1;
        dwe <= w;
        da <= a;
        @(posedge clk);
        dv <= 1'b0;
    endtask
    // Expects a halt with the given cause; the caller waits for the probe to resume.
    task automatic halt_cause(input logic [2:0] c, input string m);
        wait_lvl(1'b1, 20);
        chk(hlt, 1'b1, m);
        chk(cause, c, m);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 3000);
        fail_count++;
        give_verdict();
    end
    initial begin
        // Reset is the top bit, so the design starts held in reset.
        {rst, prst, frc, tfe, sfe, obe, rse, swe} = 8'h80;
        {fv, ret, sby, dv, dwe} = 5'h00;
        opin = 1'b1;
        fa = 20'h00000;
        npc = 20'h00000;
        da = 20'h00000;
        swa = 20'h00000;
        dly = 8'h03;
        for (int i = 0; i < `OCB_NSLOT; i++) begin
            smode[i] = OCB_SLOT_OFF;
            saddr[i] = 20'h00000;
            sacc[i] = 2'h0;
        end
        cyc(2);
        rst <= 1'b0;
        smode[0] <= OCB_SLOT_EXEC_PRE;
        saddr[0] <= 20'h00100;
        fetch(20'h00100);
        halt_cause(`OCB_CAUSE_EXEC_PRE, "pre");
        chk(hpc, 20'h00100, "pre pc");
        chk(stall, 1'b1, "pre stall");
        wait_lvl(1'b0, 20);
        $display("test pre done");
        smode[1] <= OCB_SLOT_ACCESS;
        saddr[1] <= 20'h00200;
        sacc[1] <= 2'h2;
        dacc(20'h00200, 1'b0);
        cyc(3);
        chk(hlt, 1'b0, "read ignored");
        dacc(20'h00200, 1'b1);
        halt_cause(`OCB_CAUSE_ACCESS, "access");
        wait_lvl(1'b0, 20);
        $display("test access done");
        smode[2] <= OCB_SLOT_EXEC_POST;
        saddr[2] <= 20'h00300;
        fetch(20'h00300);
        cyc(2);
        chk(hlt, 1'b0, "post early");
        ret <= 1'b1;
        npc <= 20'h00302;
        @(posedge clk);
        ret <= 1'b0;
        halt_cause(`OCB_CAUSE_EXEC_POST, "post");
        chk(hpc, 20'h00302, "post pc");
        wait_lvl(1'b0, 20);
        $display("test post done");
        swa <= 20'h00400;
        swe <= 1'b1;
        fetch(20'h00400);
        halt_cause(`OCB_CAUSE_SWBRK, "swbrk");
        swe <= 1'b0;
        wait_lvl(1'b0, 20);
        $display("test swbrk done");
        {tfe, sfe, obe, sby, frc} <= 5'h1f;
        npc <= 20'h00501;
        dly <= 8'h28;
        halt_cause(`OCB_CAUSE_FORCED, "forced");
        chk(wake, 1'b1, "wake");
        chk(hpc, 20'h00501, "standby pc");
        chk({tfo, sfo, oeo}, 3'h6, "freeze on");
        {sby, frc} <= 2'h0;
        cyc(20);
        chk(hlt, 1'b1, "sticky");
        wait_lvl(1'b0, 60);
        chk({tfo, sfo, oeo}, 3'h1, "freeze off");
        {tfe, sfe, obe, frc} <= 4'h1;
        dly <= 8'h05;
        halt_cause(`OCB_CAUSE_FORCED, "defaults");
        chk({tfo, sfo, oeo, obo}, 4'h3, "run on");
        frc <= 1'b0;
        wait_lvl(1'b0, 30);
        $display("test forced done");
        rse <= 1'b1;
        prst <= 1'b1;
        k = 0;
        while (rbusy !== 1'b1 && k < 10) begin
            @(posedge clk);
            #1;
            k++;
        end
        k = 0;
        while (rbusy === 1'b1 && stall === 1'b1 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(k >= RC && k < 40, 1'b1, "restore hold");
        {rse, prst} <= 2'h0;
        cyc(4);
        prst <= 1'b1;
        cyc(8);
        chk({rbusy, stall}, 2'h0, "no restore");
        $display("test restore done");
        give_verdict();
    end
endmodule
